// ==== rtl/aare_engine.sv ====
// Purpose: auto acknowledge and resend engine of the link layer
// Assumes: packet framer handles bits; this block sequences frames
// Notes: registers over a plain strobe port, read data one cycle later
// Functional notes
// - auto ack only when enable bit set
// - sent no-ack field copies suppress setting
// - after ack request, listen; lost suppresses sent
// - ack destination equals received source
// - ack source from source address register
// - ack sequence equals received sequence
// - piggyback flag and fifo data gives payload
// - otherwise empty ack with addresses, sequence
// - fifo read per ack; empty underflows
// - ack no-ack flag is always one
// - ack accepted: no timeout, unfiltered, sequence matches
// - auto ack only with stacked format
// - piggyback ack never itself acknowledged/resent
// - repeated packet re-acked with same payload
// - resend limit 0 to 15, zero disables
// - attempt counter ends at most limit+1
// - limit reached raises irq, fifo kept
// - resend from retained fifo, no refill
// - rx timer: clock/1210, (pre+1)*cnt-1 ticks
// - wake timer: rc/1..8, (pre+1)*(cnt+1)
`timescale 1ns/1ps
`default_nettype none
module aare_engine (
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [aare_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [aare_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [aare_pkg::DATA_W-1:0] reg_rdata_o,
  // frame transmitter
  output logic frm_tx_start_o,
  output logic frm_tx_noack_o,
  output logic frm_tx_is_ack_o,
  output logic [7:0] frm_tx_dst_o,
  output logic [7:0] frm_tx_src_o,
  output logic [7:0] frm_tx_seq_o,
  output logic frm_tx_payload_o,
  input wire logic frm_tx_done_i,
  input wire logic [7:0] data_seq_i,
  input wire logic [7:0] data_dst_i,
  // frame receiver
  output logic frm_rx_start_o,
  output logic frm_rx_stop_o,
  input wire logic frm_rx_valid_i,
  input wire logic frm_rx_filtered_i,
  input wire logic frm_rx_noack_i,
  input wire logic [7:0] frm_rx_src_i,
  input wire logic [7:0] frm_rx_seq_i,
  // tx fifo
  input wire logic fifo_empty_i,
  output logic fifo_rd_o,
  output logic fifo_rewind_o,
  output logic fifo_flush_o,
  // oscillator and events
  input wire logic rc_tick_i,
  input wire logic wakeup_en_i,
  output logic wake_o,
  output logic data_sent_o,
  output logic resend_limit_irq_o,
  output logic fifo_underflow_o
);
  import aare_pkg::*;
  aare_state_e state_ff, nxt_state;
  logic [7:0] ctrl_ff, src_addr_ff, rx_pre_ff, rx_cnt_ff;
  logic [7:0] wu_pre_ff, wu_cnt_ff, wu_rpre_ff, wu_rcnt_ff, rssi_lim_ff;
  logic [1:0] wu_scale_ff;
  logic [3:0] max_resend_limit_ff;
  logic [4:0] resend_attempt_count_ff;
  logic [7:0] ack_dst_ff, ack_seq_ff;
  logic [7:0] last_seq_ff;
  logic last_valid_ff;
  logic piggy_ff;
  logic underflow_ff, limit_ff;
  logic [7:0] rdata_ff;
  logic sent_ff, irq_ff, tx_start_ff, rx_start_ff, rx_stop_ff, rd_ff;
  logic rewind_ff, flush_ff;
  logic rx_expired;
  // register decode
  wire logic wr_ctrl = reg_wr_i && (reg_addr_i == OFF_CTRL);
  wire logic wr_cmd = reg_wr_i && (reg_addr_i == OFF_CMD);
  wire logic cmd_tx = wr_cmd && (reg_wdata_i == CMD_TX);
  wire logic cmd_rx = wr_cmd && (reg_wdata_i == CMD_RX);
  wire logic cmd_flush = wr_cmd && (reg_wdata_i == CMD_FLUSH);
  wire logic cmd_reload = wr_cmd && (reg_wdata_i == CMD_WU_RELOAD);
  wire logic cmd_abort = wr_cmd && (reg_wdata_i == CMD_ABORT);
  wire logic auto_ack = ctrl_ff[CTRL_AUTO_ACK]
    && ctrl_ff[CTRL_STACK_FMT];
  wire logic ack_req = !ctrl_ff[CTRL_SUPPRESS];
  wire logic resend_on = (max_resend_limit_ff != 4'h0);
  wire logic [4:0] attempt_cap = 5'(max_resend_limit_ff) + 5'd1;
  // a packet from the peer is the ack when its sequence matches
  wire logic ack_hit = frm_rx_valid_i && !frm_rx_filtered_i
    && (frm_rx_seq_i == data_seq_i);
  wire logic rx_good = frm_rx_valid_i && !frm_rx_filtered_i;
  wire logic peer_wants_ack = rx_good && !frm_rx_noack_i;
  wire logic repeat_pkt = last_valid_ff && (frm_rx_seq_i == last_seq_ff);
  wire logic lost = rx_expired || (frm_rx_valid_i && !ack_hit);
  wire logic at_limit = !resend_on
    || (resend_attempt_count_ff >= attempt_cap);
  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      AARE_IDLE: begin
        if (cmd_tx && !auto_ack) nxt_state = AARE_SEND;
        else if (cmd_rx && !resend_on) nxt_state = AARE_LISTEN;
      end
      AARE_SEND: begin
        if (frm_tx_done_i) nxt_state = ack_req ? AARE_WAIT : AARE_IDLE;
      end
      AARE_WAIT: begin
        if (cmd_abort || ack_hit) nxt_state = AARE_IDLE;
        else if (lost) nxt_state = at_limit ? AARE_IDLE : AARE_SEND;
      end
      AARE_LISTEN: begin
        if (cmd_abort || rx_expired) nxt_state = AARE_IDLE;
        else if (peer_wants_ack && auto_ack) nxt_state = AARE_ACK;
        else if (rx_good) nxt_state = AARE_IDLE;
      end
      AARE_ACK: begin
        if (frm_tx_done_i) nxt_state = AARE_IDLE;
      end
      default: nxt_state = AARE_IDLE;
    endcase
  end
  wire logic enter_send = (nxt_state == AARE_SEND) && (state_ff != AARE_SEND);
  wire logic enter_ack = (nxt_state == AARE_ACK) && (state_ff != AARE_ACK);
  wire logic enter_wait = (nxt_state == AARE_WAIT) && (state_ff != AARE_WAIT);
  wire logic enter_listen = (nxt_state == AARE_LISTEN)
    && (state_ff != AARE_LISTEN);
  wire logic retry = (state_ff == AARE_WAIT) && (nxt_state == AARE_SEND);
  wire logic give_up = (state_ff == AARE_WAIT) && lost && at_limit
    && !ack_hit && !cmd_abort;
  // fsm and control registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff <= AARE_IDLE;
      ctrl_ff <= RST_REG;
      src_addr_ff <= RST_REG;
      max_resend_limit_ff <= 4'h0;
      wu_scale_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      if (wr_ctrl) ctrl_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == OFF_SRC_ADDR) src_addr_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == OFF_RESEND) begin
        max_resend_limit_ff <= reg_wdata_i[3:0];
      end
      if (reg_wr_i && reg_addr_i == OFF_WU_SCALE) begin
        wu_scale_ff <= reg_wdata_i[1:0];
      end
    end
  end
  // timer and rssi limit registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_pre_ff <= RST_RX_TMO_PRE;
      rx_cnt_ff <= RST_RX_TMO_CNT;
      wu_pre_ff <= RST_REG;
      wu_cnt_ff <= RST_REG;
      wu_rpre_ff <= RST_REG;
      wu_rcnt_ff <= RST_REG;
      rssi_lim_ff <= RST_REG;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFF_RX_TMO_PRE) rx_pre_ff <= reg_wdata_i;
      if (reg_addr_i == OFF_RX_TMO_CNT) rx_cnt_ff <= reg_wdata_i;
      if (reg_addr_i == OFF_WU_PRE) wu_pre_ff <= reg_wdata_i;
      if (reg_addr_i == OFF_WU_CNT) wu_cnt_ff <= reg_wdata_i;
      if (reg_addr_i == OFF_WU_RLD_PRE) wu_rpre_ff <= reg_wdata_i;
      if (reg_addr_i == OFF_WU_RLD_CNT) wu_rcnt_ff <= reg_wdata_i;
      if (reg_addr_i == OFF_RSSI_LIMIT) rssi_lim_ff <= reg_wdata_i;
    end
  end
  // attempt counter and remembered frames
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      resend_attempt_count_ff <= 5'h00;
      ack_dst_ff <= RST_REG;
      ack_seq_ff <= RST_REG;
      last_seq_ff <= RST_REG;
      last_valid_ff <= 1'b0;
      piggy_ff <= 1'b0;
    end else begin
      if (cmd_tx && state_ff == AARE_IDLE) begin
        resend_attempt_count_ff <= 5'd1;
      end else if (retry) begin
        resend_attempt_count_ff <= resend_attempt_count_ff + 5'd1;
      end
      if (enter_ack) begin
        ack_dst_ff <= frm_rx_src_i;
        ack_seq_ff <= frm_rx_seq_i;
        // a repeated packet resends the payload kept in the fifo
        piggy_ff <= ctrl_ff[CTRL_PIGGY] && !fifo_empty_i;
        last_seq_ff <= frm_rx_seq_i;
        last_valid_ff <= 1'b1;
      end
      if (cmd_flush) last_valid_ff <= 1'b0;
    end
  end
  // pulses and sticky status
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_start_ff <= 1'b0;
      rx_start_ff <= 1'b0;
      rx_stop_ff <= 1'b0;
      rd_ff <= 1'b0;
      rewind_ff <= 1'b0;
      flush_ff <= 1'b0;
      sent_ff <= 1'b0;
      irq_ff <= 1'b0;
      underflow_ff <= 1'b0;
      limit_ff <= 1'b0;
    end else begin
      tx_start_ff <= enter_send || enter_ack;
      rx_start_ff <= enter_wait || enter_listen;
      rx_stop_ff <= (state_ff == AARE_WAIT || state_ff == AARE_LISTEN)
        && (nxt_state == AARE_IDLE || nxt_state == AARE_SEND
        || nxt_state == AARE_ACK);
      rd_ff <= enter_ack;
      // the same fifo contents are replayed, never refilled
      rewind_ff <= retry || (enter_ack && repeat_pkt);
      flush_ff <= cmd_flush;
      // sent only on ack or when no ack was asked
      sent_ff <= ((state_ff == AARE_WAIT) && ack_hit)
        || ((state_ff == AARE_SEND) && frm_tx_done_i && !ack_req);
      irq_ff <= give_up;
      if (enter_ack && fifo_empty_i) underflow_ff <= 1'b1;
      else if (cmd_flush) underflow_ff <= 1'b0;
      if (give_up) limit_ff <= 1'b1;
      else if (reg_rd_i && reg_addr_i == OFF_STATUS) limit_ff <= 1'b0;
    end
  end
  // read mux
  wire logic [7:0] status_val = {1'b0, limit_ff, underflow_ff,
    (state_ff == AARE_IDLE), 4'h0};
  wire logic [7:0] rd_mux =
    (reg_addr_i == OFF_CTRL) ? ctrl_ff :
    (reg_addr_i == OFF_RESEND) ? {3'h0, resend_attempt_count_ff} :
    (reg_addr_i == OFF_SRC_ADDR) ? src_addr_ff :
    (reg_addr_i == OFF_STATUS) ? status_val :
    (reg_addr_i == OFF_WU_SCALE) ? {6'h00, wu_scale_ff} :
    (reg_addr_i == OFF_RX_TMO_CNT) ? rx_cnt_ff :
    (reg_addr_i == OFF_RX_TMO_PRE) ? rx_pre_ff :
    (reg_addr_i == OFF_WU_PRE) ? wu_pre_ff :
    (reg_addr_i == OFF_WU_CNT) ? wu_cnt_ff :
    (reg_addr_i == OFF_WU_RLD_PRE) ? wu_rpre_ff :
    (reg_addr_i == OFF_WU_RLD_CNT) ? wu_rcnt_ff :
    (reg_addr_i == OFF_RSSI_LIMIT) ? rssi_lim_ff : 8'h00;
  always_ff @(posedge clock_i) begin
    if (rst_i) rdata_ff <= RST_REG;
    else rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
  end
  aare_rx_timer u_rx_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(rx_start_ff),
    .stop_i(rx_stop_ff),
    .pre_i(rx_pre_ff),
    .cnt_i(rx_cnt_ff),
    .expired_o(rx_expired)
  );
  aare_wakeup_timer u_wakeup_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(wakeup_en_i),
    .rc_tick_i(rc_tick_i),
    .scale_i(wu_scale_ff),
    .reload_i(cmd_reload),
    .pre_i(wu_pre_ff),
    .cnt_i(wu_cnt_ff),
    .rld_pre_i(wu_rpre_ff),
    .rld_cnt_i(wu_rcnt_ff),
    .wake_o(wake_o)
  );
  // frame fields
  wire logic in_ack = (state_ff == AARE_ACK);
  assign frm_tx_start_o = tx_start_ff;
  assign frm_tx_is_ack_o = in_ack;
  assign frm_tx_noack_o = in_ack ? 1'b1 : ctrl_ff[CTRL_SUPPRESS];
  assign frm_tx_dst_o = in_ack ? ack_dst_ff : data_dst_i;
  assign frm_tx_src_o = src_addr_ff;
  assign frm_tx_seq_o = in_ack ? ack_seq_ff : data_seq_i;
  assign frm_tx_payload_o = in_ack ? piggy_ff : 1'b1;
  assign frm_rx_start_o = rx_start_ff;
  assign frm_rx_stop_o = rx_stop_ff;
  assign fifo_rd_o = rd_ff;
  assign fifo_rewind_o = rewind_ff;
  assign fifo_flush_o = flush_ff;
  assign data_sent_o = sent_ff;
  assign resend_limit_irq_o = irq_ff;
  assign fifo_underflow_o = underflow_ff;
  assign reg_rdata_o = rdata_ff;
endmodule // aare_engine
`default_nettype wire

// ==== rtl/aare_pkg.sv ====
// Purpose: shared constants for the auto acknowledge / resend engine
// Assumes: 8-bit register port, 250 MHz digital clock
// Notes: offsets below 0x40 are local control and status registers
package aare_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // documented timer and rssi limit registers
  localparam logic [7:0] OFF_RX_TMO_CNT = 8'h46;
  localparam logic [7:0] OFF_RX_TMO_PRE = 8'h47;
  localparam logic [7:0] OFF_WU_PRE = 8'h48;
  localparam logic [7:0] OFF_WU_CNT = 8'h49;
  localparam logic [7:0] OFF_WU_RLD_PRE = 8'h4a;
  localparam logic [7:0] OFF_WU_RLD_CNT = 8'h4b;
  localparam logic [7:0] OFF_RSSI_LIMIT = 8'h54;
  // local registers
  localparam logic [7:0] OFF_CTRL = 8'h30;
  localparam logic [7:0] OFF_RESEND = 8'h31;
  localparam logic [7:0] OFF_SRC_ADDR = 8'h32;
  localparam logic [7:0] OFF_STATUS = 8'h33;
  localparam logic [7:0] OFF_CMD = 8'h34;
  localparam logic [7:0] OFF_WU_SCALE = 8'h35;
  // control fields
  localparam int CTRL_AUTO_ACK = 0;
  localparam int CTRL_SUPPRESS = 1;
  localparam int CTRL_PIGGY = 2;
  localparam int CTRL_STACK_FMT = 3;
  // command codes
  localparam logic [7:0] CMD_TX = 8'h01;
  localparam logic [7:0] CMD_RX = 8'h02;
  localparam logic [7:0] CMD_FLUSH = 8'h03;
  localparam logic [7:0] CMD_WU_RELOAD = 8'h04;
  localparam logic [7:0] CMD_ABORT = 8'h05;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_RX_TMO_PRE = 8'h01;
  localparam logic [7:0] RST_RX_TMO_CNT = 8'h01;
  // rx timer tick divider: digital clock / 1210
  localparam int RX_TICK_DIV = 1210;
  localparam logic [10:0] RX_TICK_LAST = 11'(RX_TICK_DIV - 1);
  localparam logic [3:0] RESEND_MAX = 4'hf;
  typedef enum logic [2:0] {
    AARE_IDLE = 3'b000,
    AARE_SEND = 3'b001,
    AARE_WAIT = 3'b011,
    AARE_LISTEN = 3'b010,
    AARE_ACK = 3'b110
  } aare_state_e;
endpackage : aare_pkg

// ==== rtl/aare_rx_timer.sv ====
// Purpose: rx window timer, ticks at clock / 1210
// Assumes: start is a one-cycle pulse
// Notes: window is (pre+1)*cnt-1 ticks, zero counter means no limit
`timescale 1ns/1ps
`default_nettype none
module aare_rx_timer (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [7:0] pre_i,
  input wire logic [7:0] cnt_i,
  output logic expired_o
);
  import aare_pkg::*;
  logic [10:0] div_ff;
  logic [16:0] ticks_ff;
  logic run_ff;
  logic exp_ff;
  wire logic tick = (div_ff == RX_TICK_LAST);
  wire logic [16:0] span = 17'((17'(pre_i) + 17'd1) * 17'(cnt_i));
  wire logic done = run_ff && tick && (cnt_i != 8'h00)
    && (ticks_ff + 17'd1 >= span - 17'd1);
  always_ff @(posedge clock_i) begin
    if (rst_i || start_i || !run_ff || tick) begin
      div_ff <= 11'h000;
    end else begin
      div_ff <= div_ff + 11'h001;
    end
    if (rst_i || start_i) begin
      ticks_ff <= 17'h00000;
    end else if (run_ff && tick) begin
      ticks_ff <= ticks_ff + 17'd1;
    end
    if (rst_i || stop_i || done) begin
      run_ff <= 1'b0;
    end else if (start_i) begin
      run_ff <= 1'b1;
    end
    exp_ff <= !rst_i && done && !start_i && !stop_i;
  end
  assign expired_o = exp_ff;
endmodule // aare_rx_timer
`default_nettype wire

// ==== rtl/aare_wakeup_timer.sv ====
// Purpose: periodic wake-up timer on the rc oscillator enable
// Assumes: rc_tick_i is a one-cycle pulse per oscillator period
// Notes: period (pre+1)*(cnt+1) scaled ticks
`timescale 1ns/1ps
`default_nettype none
module aare_wakeup_timer (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic rc_tick_i,
  input wire logic [1:0] scale_i,
  input wire logic reload_i,
  input wire logic [7:0] pre_i,
  input wire logic [7:0] cnt_i,
  input wire logic [7:0] rld_pre_i,
  input wire logic [7:0] rld_cnt_i,
  output logic wake_o
);
  import aare_pkg::*;
  logic [2:0] sc_ff;
  logic [7:0] pre_ff;
  logic [7:0] cnt_ff;
  logic wake_ff;
  wire logic [2:0] sc_last = 3'((4'd1 << scale_i) - 4'd1);
  wire logic step = rc_tick_i && (sc_ff == sc_last);
  wire logic pre_end = (pre_ff == 8'h00);
  wire logic wrap = step && pre_end && (cnt_ff == 8'h00);
  always_ff @(posedge clock_i) begin
    if (rst_i || !enable_i) begin
      sc_ff <= 3'h0;
      pre_ff <= pre_i;
      cnt_ff <= cnt_i;
    end else if (reload_i) begin
      pre_ff <= rld_pre_i;
      cnt_ff <= rld_cnt_i;
    end else begin
      if (rc_tick_i) sc_ff <= step ? 3'h0 : sc_ff + 3'h1;
      if (step) begin
        pre_ff <= pre_end ? pre_i : pre_ff - 8'h01;
        if (pre_end) cnt_ff <= wrap ? cnt_i : cnt_ff - 8'h01;
      end
    end
    wake_ff <= !rst_i && enable_i && wrap;
  end
  assign wake_o = wake_ff;
endmodule // aare_wakeup_timer
`default_nettype wire

// ==== testbench/aare_engine_sva.sv ====
// Purpose: port checks on the auto ack and resend engine
// Assumes: one clock, synchronous reset
// Notes: helper regs mirror host writes and received headers
`timescale 1ns/1ps
`default_nettype none
module aare_engine_sva
  import aare_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [aare_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [aare_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [aare_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic frm_tx_start_o,
  input wire logic frm_tx_noack_o,
  input wire logic frm_tx_is_ack_o,
  input wire logic [7:0] frm_tx_dst_o,
  input wire logic [7:0] frm_tx_src_o,
  input wire logic [7:0] frm_tx_seq_o,
  input wire logic frm_tx_payload_o,
  input wire logic frm_tx_done_i,
  input wire logic frm_rx_start_o,
  input wire logic frm_rx_valid_i,
  input wire logic [7:0] frm_rx_src_i,
  input wire logic [7:0] frm_rx_seq_i,
  input wire logic fifo_empty_i,
  input wire logic fifo_rd_o,
  input wire logic fifo_underflow_o,
  input wire logic resend_limit_irq_o
);
  logic [7:0] ctl_ff, src_ff, rsrc_ff, rseq_ff;
  logic [4:0] lim_ff, att_ff;
  logic ack_ff, nak_ff;
  wire wr_ctl = reg_wr_i && reg_addr_i == OFF_CTRL;
  wire wr_src = reg_wr_i && reg_addr_i == OFF_SRC_ADDR;
  wire wr_lim = reg_wr_i && reg_addr_i == OFF_RESEND;
  wire tx_cmd = reg_wr_i && reg_addr_i == OFF_CMD && reg_wdata_i == CMD_TX;
  wire ack_go = frm_tx_start_o && frm_tx_is_ack_o;
  wire data_go = frm_tx_start_o && !frm_tx_is_ack_o;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctl_ff <= '0;
      src_ff <= '0;
      lim_ff <= '0;
      att_ff <= '0;
    end else begin
      if (wr_ctl) ctl_ff <= reg_wdata_i;
      if (wr_src) src_ff <= reg_wdata_i;
      if (wr_lim) lim_ff <= {1'b0, reg_wdata_i[3:0]};
      if (tx_cmd) att_ff <= '0;
      else if (data_go) att_ff <= att_ff + 5'h1;
    end
  end
  always_ff @(posedge clock_i) begin
    if (frm_rx_valid_i) rsrc_ff <= frm_rx_src_i;
    if (frm_rx_valid_i) rseq_ff <= frm_rx_seq_i;
    if (frm_tx_start_o) ack_ff <= frm_tx_is_ack_o;
    if (frm_tx_start_o) nak_ff <= frm_tx_noack_o;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data not zero outside a read");
  ack_gate_a: assert property ($rose(frm_tx_is_ack_o) |->
    ctl_ff[CTRL_AUTO_ACK] && ctl_ff[CTRL_STACK_FMT])
    else $error("ack sent while auto ack is off");
  ack_hdr_a: assert property (ack_go |->
    frm_tx_dst_o == rsrc_ff && frm_tx_seq_o == rseq_ff)
    else $error("ack header wrong");
  ack_src_a: assert property (ack_go |-> frm_tx_src_o == src_ff)
    else $error("ack source wrong");
  ack_noack_a: assert property (ack_go |-> frm_tx_noack_o)
    else $error("ack requests an ack");
  ack_empty_a: assert property (ack_go && fifo_empty_i |->
    !frm_tx_payload_o) else $error("payload from empty fifo");
  data_noack_a: assert property (data_go |->
    frm_tx_noack_o == ctl_ff[CTRL_SUPPRESS]) else $error("no-ack bit wrong");
  listen_a: assert property (frm_tx_done_i && !ack_ff && !nak_ff |->
    ##1 frm_rx_start_o) else $error("no listen after ack request");
  ack_read_a: assert property ($rose(frm_tx_is_ack_o) |->
    ##[0:3] fifo_rd_o) else $error("no fifo read for ack");
  under_set_a: assert property (fifo_rd_o && fifo_empty_i |=>
    fifo_underflow_o) else $error("underflow not raised");
  irq_count_a: assert property (resend_limit_irq_o |->
    att_ff == lim_ff + 5'h1) else $error("attempt count at limit wrong");
  irq_stop_a: assert property (resend_limit_irq_o |=>
    !frm_tx_start_o [*8]) else $error("attempt after limit");
endmodule // aare_engine_sva
bind aare_engine aare_engine_sva aare_engine_sva_inst (.clock_i, .rst_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .frm_tx_start_o, .frm_tx_noack_o, .frm_tx_is_ack_o, .frm_tx_dst_o,
  .frm_tx_src_o, .frm_tx_seq_o, .frm_tx_payload_o, .frm_tx_done_i,
  .frm_rx_start_o, .frm_rx_valid_i, .frm_rx_src_i, .frm_rx_seq_i,
  .fifo_empty_i, .fifo_rd_o, .fifo_underflow_o, .resend_limit_irq_o);
`default_nettype wire

// ==== testbench/aare_peer.sv ====
// Purpose: peer transceiver and framer stand-in
// Assumes: answers a listen window only when ans_i is set
// Notes: qualifiers show other values outside valid
`timescale 1ns/1ps
`default_nettype none
module aare_peer #(parameter int DLY = 10) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tx_start_i,
  input wire logic rx_start_i,
  input wire logic ans_i,
  input wire logic noack_i,
  input wire logic [7:0] seq_i,
  output logic tx_done_o,
  output logic valid_o,
  output logic filt_o,
  output logic noack_o,
  output logic [7:0] src_o,
  output logic [7:0] seq_o
);
  int txc, rxc;
  always @(posedge clock_i) begin
    if (tx_start_i) txc = DLY;
    else if (txc > 0) txc--;
    // answers listen windows only, never a frame it got as ack
    if (rx_start_i && ans_i) rxc = 6;
    else if (rxc > 0) rxc--;
    if (rst_i) begin
      txc = 0;
      rxc = 0;
    end
    tx_done_o <= txc == 1;
    valid_o <= rxc == 1;
  end
  assign filt_o = !valid_o;
  assign noack_o = valid_o ? noack_i : !noack_i;
  assign src_o = valid_o ? 8'h21 : 8'hde;
  assign seq_o = valid_o ? seq_i : ~seq_i;
endmodule // aare_peer
`default_nettype wire

// ==== testbench/tb_aare_engine.sv ====
// Purpose: self-checking bench for the engine
// Assumes: peer model on the frame side, host on the register port
// Notes: rx window left at reset values, one tick long
`timescale 1ns/1ps
`default_nettype none
module tb_aare_engine;
  import aare_pkg::*;
  logic clock_i, rst_i, reg_wr_i, reg_rd_i, fifo_empty_i, rc_tick_i;
  logic wakeup_en_i, ans, nak, frm_tx_start_o, frm_tx_noack_o;
  logic frm_tx_is_ack_o, frm_tx_payload_o, frm_tx_done_i, frm_rx_start_o;
  logic frm_rx_stop_o, frm_rx_valid_i, frm_rx_filtered_i, frm_rx_noack_i;
  logic fifo_rd_o, fifo_rewind_o, fifo_flush_o, wake_o, data_sent_o;
  logic resend_limit_irq_o, fifo_underflow_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, data_seq_i, data_dst_i;
  logic [7:0] frm_tx_dst_o, frm_tx_src_o, frm_tx_seq_o, frm_rx_src_i;
  logic [7:0] frm_rx_seq_i, aseq, d;
  logic [2:0] rc_ff;
  int n_fail, tests_run, n_tx, n_rd, n_rw, n_sent, n_irq, n_fl;
  aare_engine aare_engine_inst (.clock_i, .rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .frm_tx_start_o,
    .frm_tx_noack_o, .frm_tx_is_ack_o, .frm_tx_dst_o, .frm_tx_src_o,
    .frm_tx_seq_o, .frm_tx_payload_o, .frm_tx_done_i, .data_seq_i,
    .data_dst_i, .frm_rx_start_o, .frm_rx_stop_o, .frm_rx_valid_i,
    .frm_rx_filtered_i, .frm_rx_noack_i, .frm_rx_src_i, .frm_rx_seq_i,
    .fifo_empty_i, .fifo_rd_o, .fifo_rewind_o, .fifo_flush_o, .rc_tick_i,
    .wakeup_en_i, .wake_o, .data_sent_o, .resend_limit_irq_o,
    .fifo_underflow_o);
  aare_peer aare_peer_inst (.clock_i, .rst_i, .tx_start_i(frm_tx_start_o),
    .rx_start_i(frm_rx_start_o), .ans_i(ans), .noack_i(nak), .seq_i(aseq),
    .tx_done_o(frm_tx_done_i), .valid_o(frm_rx_valid_i),
    .filt_o(frm_rx_filtered_i), .noack_o(frm_rx_noack_i),
    .src_o(frm_rx_src_i), .seq_o(frm_rx_seq_i));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    rc_ff <= rc_ff + 3'h1;
    rc_tick_i <= rc_ff == 3'h7;
    n_tx += frm_tx_start_o;
    n_rd += fifo_rd_o;
    n_rw += fifo_rewind_o;
    n_sent += data_sent_o;
    n_irq += resend_limit_irq_o;
    n_fl += fifo_flush_o;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic clr;
    n_tx = 0;
    n_rd = 0;
    n_rw = 0;
    n_sent = 0;
    n_irq = 0;
    n_fl = 0;
  endtask
  task automatic idle_wait;
    repeat (4) @(posedge clock_i);
    for (int i = 0; i < 15000; i++) begin
      rd(OFF_STATUS);
      if (d[4] === 1'b1) break;
    end
    ans <= 1'b0;
  endtask
  task automatic s_regs;
    rd(OFF_RX_TMO_PRE);
    chk(d, RST_RX_TMO_PRE);
    rd(OFF_RX_TMO_CNT);
    chk(d, RST_RX_TMO_CNT);
    wr(OFF_SRC_ADDR, 8'h5a);
    rd(OFF_SRC_ADDR);
    chk(d, 8'h5a);
    rd(8'h7f);
    chk(d, 8'h00);
  endtask
  task automatic s_off;
    for (int i = 0; i < 2; i++) begin
      wr(OFF_CTRL, i == 0 ? 8'h08 : 8'h01);
      clr();
      ans <= 1'b1;
      wr(OFF_CMD, CMD_RX);
      idle_wait();
      chk(8'(n_tx), 8'h00);
    end
  endtask
  task automatic s_ack(input logic [7:0] ctl, input logic emp,
                       input logic [7:0] sq, input logic [7:0] rw);
    fifo_empty_i <= emp;
    wr(OFF_CTRL, ctl);
    aseq <= sq;
    ans <= 1'b1;
    clr();
    wr(OFF_CMD, CMD_RX);
    for (int i = 0; i < 3000 && frm_tx_start_o !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    chk(frm_tx_is_ack_o, 1'b1);
    chk(frm_tx_noack_o, 1'b1);
    chk(frm_tx_dst_o, 8'h21);
    chk(frm_tx_src_o, 8'h5a);
    chk(frm_tx_seq_o, sq);
    chk(frm_tx_payload_o, ctl[2] & !emp);
    idle_wait();
    chk(8'(n_rd), 8'h01);
    chk(8'(n_rw), rw);
    chk(fifo_underflow_o, emp);
  endtask
  task automatic s_tx(input logic [7:0] lim, input logic a,
                      input logic [7:0] sq, input logic [7:0] etx,
                      input logic [7:0] esent);
    fifo_empty_i <= 1'b0;
    wr(OFF_CTRL, 8'h00);
    wr(OFF_RESEND, lim);
    ans <= a;
    aseq <= sq;
    clr();
    wr(OFF_CMD, CMD_TX);
    idle_wait();
    chk(8'(n_tx), etx);
    chk(8'(n_sent), esent);
    if (lim != 0) chk(8'(n_irq), 8'h01 - esent);
    chk(8'(n_rw), etx - 8'h01);
    chk(8'(n_fl), 8'h00);
    rd(OFF_RESEND);
    chk(d, etx);
  endtask
  task automatic wk_wait(output int c);
    c = 0;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clock_i);
      #1 c++;
      if (wake_o === 1'b1) break;
    end
  endtask
  task automatic s_wake;
    int c;
    wakeup_en_i <= 1'b1;
    for (int a = 0; a < 4; a++) wr(OFF_WU_PRE + 8'(a), 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_WU_SCALE, 8'(s));
      wr(OFF_CMD, CMD_WU_RELOAD);
      repeat (3) wk_wait(c);
      chk(8'(c >> s), 8'h20);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {reg_wr_i, reg_rd_i, rc_tick_i, wakeup_en_i, ans, nak} = '0;
    {reg_addr_i, reg_wdata_i, aseq, rc_ff} = '0;
    fifo_empty_i = 1'b1;
    data_seq_i = 8'h44;
    data_dst_i = 8'h21;
    rst_i = 1'b1;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    s_regs();
    s_off();
    s_ack(8'h09, 1'b1, 8'h07, 8'h00);
    wr(OFF_CMD, CMD_FLUSH);
    repeat (3) @(posedge clock_i);
    chk(fifo_underflow_o, 1'b0);
    s_ack(8'h0d, 1'b0, 8'h08, 8'h00);
    s_ack(8'h0d, 1'b0, 8'h08, 8'h01);
    nak <= 1'b1;
    s_tx(8'h02, 1'b0, 8'h00, 8'h03, 8'h00);
    s_tx(8'h01, 1'b1, 8'h45, 8'h02, 8'h00);
    s_tx(8'h03, 1'b1, 8'h44, 8'h01, 8'h01);
    s_tx(8'h00, 1'b0, 8'h00, 8'h01, 8'h00);
    s_tx(8'h0f, 1'b0, 8'h00, 8'h10, 8'h00);
    s_wake();
    tally_and_finish();
  end
endmodule // tb_aare_engine
`default_nettype wire
